// [src/spop_lane_ser.sv]
// Purpose: one double data rate lane shifter
// Assumes: load pulses once per word slot on the link clock
// Notes: msb first, two bits per link clock, [1] is the rising edge bit
`timescale 1ns/100ps
`default_nettype none
module spop_lane_ser #(
   parameter int W = 10
) (
   // link clock
   input wire logic clk_i,
   input wire logic rst_n_i,
   // word in
   input wire logic load_i,
   input wire logic [W-1:0] word_i,
   // ddr pair out
   output logic [1:0] ddr_o
);
   logic [W-1:0] sh_reg;

   // in 8-bit mode the slot ends after three shifts, so only the top byte leaves
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         sh_reg <= '0;
      else if (load_i)
         sh_reg <= word_i; // RULE5
      else
         sh_reg <= {sh_reg[W-3:0], 2'h0}; // RULE14
   end

   assign ddr_o = sh_reg[W-1:W-2];
endmodule // spop_lane_ser
`default_nettype wire

// [src/spop_output_path.sv]
// Purpose: formatter, crc, sync codes, ddr lanes and parallel port
// Assumes: items come from same-domain logic; lnk_clk_i runs free
// Notes: one word slot crosses to the link domain by a toggle handshake
`timescale 1ns/100ps
`default_nettype none
module spop_output_path (
   // clocks and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic lnk_clk_i,
   // configuration
   input wire logic mode8_i,
   input wire logic use_ext_clk_i,
   // samples and frame timing from the front end
   input wire spop_pkg::spop_item_t item_i,
   input wire logic item_valid_i,
   output logic item_ready_o,
   // serial lanes
   output logic [7:0] dat_ddr_o,
   output logic [1:0] sync_ddr_o,
   output logic [1:0] clk_ddr_o,
   // clocking
   output logic pll_en_o,
   // parallel port
   output logic [9:0] par_data_o,
   output logic par_fv_o,
   output logic par_lv_o
);
   import spop_pkg::*;

   spop_st_t st_reg;
   spop_slot_t slot_next;
   spop_slot_t bundle_reg;
   logic [NUM_CH-1:0][WORD_W-1:0] odd_reg;
   logic [NUM_CH-1:0][WORD_W-1:0] crc_reg;
   logic [9:0] last_sync_reg;
   logic req_reg;
   logic ack_s1_reg;
   logic ack_s2_reg;
   logic ext_s1_reg;
   logic ext_s2_reg;
   logic pll_en_reg;
   logic busy;
   logic take;
   logic launch;

   // link side
   logic lrst_s1_reg;
   logic lrst_s2_reg;
   logic lnk_rst_n;
   logic req_s1_reg;
   logic req_s2_reg;
   logic m8_s1_reg;
   logic m8_s2_reg;
   logic m8_slot_reg;
   logic ack_reg;
   logic pend_reg;
   spop_slot_t cap_reg;
   spop_slot_t cur_reg;
   spop_slot_t lane_slot;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_last;
   logic load;
   logic fv_reg;
   logic lv_reg;
   logic [9:0] par_reg;
   logic lnk_up_reg;
   logic [5:0][WORD_W-1:0] lane_word;
   logic [5:0][1:0] lane_ddr;

   function automatic logic [9:0] fmt(input logic m8, input logic [9:0] w);
      return m8 ? {w[9:2], 2'h0} : w;
   endfunction

   // handshake and flow control on the system clock
   assign busy = req_reg ^ ack_s2_reg;
   assign item_ready_o = (st_reg == S_IDLE) && !busy;
   assign take = item_valid_i && item_ready_o;
   assign launch = take || ((st_reg != S_IDLE) && !busy);

   always_comb
   begin
      slot_next.sync = CODE_TRAIN;
      slot_next.dat = '0;
      case (st_reg)
         S_IDLE:
         begin
            case (item_i.kind)
               K_PIX:
               begin
                  slot_next.sync = CODE_IMG;
                  for (int k = 0; k < NUM_CH; k++)
                     slot_next.dat[k] = fmt(mode8_i, item_i.smp[2*k]); // RULE1
               end
               K_FS: slot_next.sync = CODE_FS; // RULE4
               K_LS: slot_next.sync = CODE_LS; // RULE4
               K_LE:
               begin
                  slot_next.sync = CODE_CRC;
                  slot_next.dat = crc_reg; // RULE15
               end
               K_FE: slot_next.sync = CODE_FE; // RULE4
               default: slot_next.sync = CODE_TRAIN;
            endcase
         end
         S_ODD:
         begin
            slot_next.sync = CODE_IMG;
            slot_next.dat = odd_reg; // RULE1
         end
         S_LE: slot_next.sync = CODE_LE; // RULE4
         default: slot_next.sync = CODE_TRAIN;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         st_reg <= S_IDLE;
      else if (take && (item_i.kind == K_PIX))
         st_reg <= S_ODD; // RULE1
      else if (take && (item_i.kind == K_LE))
         st_reg <= S_LE; // RULE15
      else if ((st_reg != S_IDLE) && !busy)
         st_reg <= S_IDLE;
   end

   // the odd adc of each pair is held for the second slot
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         odd_reg <= '0;
      else if (take && (item_i.kind == K_PIX))
         for (int k = 0; k < NUM_CH; k++)
            odd_reg[k] <= fmt(mode8_i, item_i.smp[2*k+1]); // RULE1
   end

   // crc runs over the words really sent, so 8-bit mode checks truncated words
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         crc_reg <= {NUM_CH{CRC_SEED}};
      else if (launch && (slot_next.sync == CODE_LS))
         crc_reg <= {NUM_CH{CRC_SEED}}; // RULE3
      else if (launch && (slot_next.sync == CODE_IMG))
         for (int k = 0; k < NUM_CH; k++)
            crc_reg[k] <= spop_crc_step(crc_reg[k], slot_next.dat[k]); // RULE3
   end

   // bundle stays stable until the link side acknowledges it
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         bundle_reg <= '0;
         req_reg <= 1'b0;
         last_sync_reg <= CODE_TRAIN;
      end
      else if (launch)
      begin
         bundle_reg <= slot_next;
         req_reg <= !req_reg;
         last_sync_reg <= slot_next.sync;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
      end
      else
      begin
         ack_s1_reg <= ack_reg;
         ack_s2_reg <= ack_s1_reg;
      end
   end

   // pin input, synchronised before use
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         pll_en_reg <= 1'b1;
      end
      else
      begin
         ext_s1_reg <= use_ext_clk_i;
         ext_s2_reg <= ext_s1_reg;
         pll_en_reg <= !ext_s2_reg; // RULE11
      end
   end

   // with the pll off, lnk_clk_i is the external clock itself, used as is
   assign pll_en_o = pll_en_reg;

   // link domain reset and level synchronisers
   always_ff @(posedge lnk_clk_i)
   begin
      lrst_s1_reg <= rst_n_i;
      lrst_s2_reg <= lrst_s1_reg;
   end

   assign lnk_rst_n = lrst_s2_reg;

   always_ff @(posedge lnk_clk_i)
   begin
      if (!lnk_rst_n)
      begin
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         m8_s1_reg <= 1'b0;
         m8_s2_reg <= 1'b0;
      end
      else
      begin
         req_s1_reg <= req_reg;
         req_s2_reg <= req_s1_reg;
         m8_s1_reg <= mode8_i;
         m8_s2_reg <= m8_s1_reg;
      end
   end

   // slot length fixes the lane rate: word bits over two bits per clock
   assign cnt_last = m8_slot_reg ? (SLOT_8 - 3'h1) : (SLOT_10 - 3'h1); // RULE6
   assign load = (cnt_reg == cnt_last);

   // mode is taken only at a slot boundary, so a mode change never cuts a word short
   always_ff @(posedge lnk_clk_i)
   begin
      if (!lnk_rst_n)
         m8_slot_reg <= 1'b0;
      else if (load)
         m8_slot_reg <= m8_s2_reg; // RULE5
   end

   always_ff @(posedge lnk_clk_i)
   begin
      if (!lnk_rst_n)
         cnt_reg <= 3'h0;
      else if (load || (cnt_reg > cnt_last))
         cnt_reg <= 3'h0;
      else
         cnt_reg <= cnt_reg + 3'h1;
   end

   // one slot captured at a time; a free capture register acknowledges
   always_ff @(posedge lnk_clk_i)
   begin
      if (!lnk_rst_n)
      begin
         cap_reg <= '0;
         pend_reg <= 1'b0;
         ack_reg <= 1'b0;
      end
      else if ((req_s2_reg != ack_reg) && !pend_reg)
      begin
         cap_reg <= bundle_reg;
         pend_reg <= 1'b1;
         ack_reg <= req_s2_reg;
      end
      else if (load)
         pend_reg <= 1'b0;
   end

   // an empty slot sends the training word on the sync and data lanes
   always_comb
   begin
      lane_slot.sync = CODE_TRAIN;
      lane_slot.dat = {NUM_CH{CODE_TRAIN}};
      if (pend_reg)
         lane_slot = cap_reg;
   end

   always_ff @(posedge lnk_clk_i)
   begin
      if (!lnk_rst_n)
      begin
         cur_reg <= '0;
         lnk_up_reg <= 1'b0;
      end
      else if (load)
      begin
         cur_reg <= lane_slot;
         lnk_up_reg <= 1'b1;
      end
   end

   always_comb
   begin
      for (int k = 0; k < NUM_CH; k++)
         lane_word[k] = lane_slot.dat[k]; // RULE9
      lane_word[4] = lane_slot.sync; // RULE8
      lane_word[5] = CLK_PATTERN; // RULE7
   end

   // the clock lane shares the data lane shifter, which keeps skew matched
   for (genvar g = 0; g < 6; g++)
   begin : g_lane
      spop_lane_ser #(
         .W(WORD_W)
      ) u_lane (
         .clk_i(lnk_clk_i),
         .rst_n_i(lnk_rst_n),
         .load_i(load),
         .word_i(lane_word[g]),
         .ddr_o(lane_ddr[g])
      );
   end

   always_comb
   begin
      for (int k = 0; k < NUM_CH; k++)
         dat_ddr_o[2*k +: 2] = lane_ddr[k]; // RULE14
   end

   assign sync_ddr_o = lane_ddr[4]; // RULE8
   assign clk_ddr_o = lane_ddr[5]; // RULE7

   // parallel port: crc words stay off this bus, it has no room to mark them
   always_ff @(posedge lnk_clk_i)
   begin
      if (!lnk_rst_n)
      begin
         par_reg <= 10'h000;
         lv_reg <= 1'b0;
      end
      else if ((cur_reg.sync == CODE_IMG) && (cnt_reg < 3'(NUM_CH)))
      begin
         par_reg <= cur_reg.dat[cnt_reg[1:0]]; // RULE12
         lv_reg <= 1'b1; // RULE13
      end
      else
      begin
         par_reg <= 10'h000;
         lv_reg <= 1'b0;
      end
   end

   always_ff @(posedge lnk_clk_i)
   begin
      if (!lnk_rst_n)
         fv_reg <= 1'b0;
      else if (load && (lane_slot.sync == CODE_FS))
         fv_reg <= 1'b1; // RULE13
      else if (load && (lane_slot.sync == CODE_FE))
         fv_reg <= 1'b0; // RULE13
   end

   assign par_data_o = par_reg;
   assign par_fv_o = fv_reg;
   assign par_lv_o = lv_reg;

   a_pix_pair: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE1
      (take && (item_i.kind == K_PIX)) |=> (st_reg == S_ODD) throughout
      (##[0:60] (launch && (slot_next.sync == CODE_IMG))))
      else $error("odd half of pixel pair not sent");

   a_crc_then_le: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE15
      (launch && (slot_next.sync == CODE_LE)) |-> (last_sync_reg == CODE_CRC))
      else $error("line end without crc slot before it");

   a_crc_seed_ls: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE3
      (launch && (slot_next.sync == CODE_LS)) |=>
      ((crc_reg[0] == CRC_SEED) && (crc_reg[NUM_CH-1] == CRC_SEED)))
      else $error("crc not seeded at line start");

   a_pll_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE11
      $rose(ext_s2_reg) |=> !pll_en_o [*2])
      else $error("pll still on with external clock");

   a_slot_ten: assert property (@(posedge lnk_clk_i) disable iff (!lnk_rst_n) // RULE6
      (load && !m8_s2_reg) |=> !load [*4] ##1 load)
      else $error("10-bit slot not five link clocks");

   a_sync_train: assert property (@(posedge lnk_clk_i) disable iff (!lnk_rst_n) // RULE8
      (load && !pend_reg) |=> (sync_ddr_o == CODE_TRAIN[9:8]))
      else $error("empty slot not training on sync lane");

   a_clk_lane: assert property (@(posedge lnk_clk_i) disable iff (!lnk_rst_n) // RULE7
      (lnk_up_reg && !load) |=> (clk_ddr_o == 2'h2))
      else $error("clock lane pattern broken");

   a_par_lv: assert property (@(posedge lnk_clk_i) disable iff (!lnk_rst_n) // RULE13
      (load && pend_reg && (cap_reg.sync == CODE_IMG)) |-> ##2 par_lv_o ##1 par_lv_o)
      else $error("line valid missing for pixel slot");

   c_line_end: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      launch && (slot_next.sync == CODE_LE));

   c_lv_rise: cover property (@(posedge lnk_clk_i) disable iff (!lnk_rst_n)
      $rose(par_lv_o) && par_fv_o);

   c_eight_bit: cover property (@(posedge lnk_clk_i) disable iff (!lnk_rst_n)
      load && pend_reg && m8_s2_reg);
endmodule // spop_output_path
`default_nettype wire

// [src/spop_pkg.sv]
// Purpose: shared constants and types of the sensor pixel output path
// Assumes: sys clock 200 MHz, link clock is the high speed bit pair clock
// Notes: How it works list below
// How it works
// RULE1 - each formatter interleaves the words of two ADC channels into one stream.
// RULE2 - the front end hands over 8 channels of 10-bit samples at a time.
// RULE3 - a CRC per output channel runs over each line's words and is sent once per line.
// RULE4 - frame start, line start, line end and frame end codes come from the timing items.
// RULE5 - lanes shift out 10-bit words, or the top 8 bits of each word in 8-bit mode.
// RULE6 - a lane carries at most 620 Mbps with 10-bit words and 496 Mbps with 8-bit words.
// RULE7 - a clock lane is driven through the same path as the data so its edges line up.
// RULE8 - a separate sync lane carries the frame format codes.
// RULE9 - four data lanes each carry up to 62 Mpix/s, 248 Mpix/s together.
// RULE10 - an external fast clock runs at typically 310 MHz for 10-bit and 248 MHz for 8-bit.
// RULE11 - using the external fast clock turns the PLL off and the clock feeds the link directly.
// RULE12 - the parallel port merges the four channels onto one 10-bit bus.
// RULE13 - the parallel port marks frames and lines with frame valid and line valid strobes.
// RULE14 - lanes are double data rate, two bits per link clock, on four data and one sync lane.
// RULE15 - each channel's line CRC follows directly after that channel's last pixel word.
package spop_pkg;
   localparam int NUM_ADC = 8; // RULE2
   localparam int NUM_CH = 4; // RULE9
   localparam int WORD_W = 10;
   localparam int DDR_BITS = 2; // RULE14
   localparam int SYS_MHZ = 200;
   localparam int LANE_MBPS_10 = 620; // RULE6
   localparam int LANE_MBPS_8 = 496; // RULE6
   localparam int CH_MPIX = 62; // RULE9
   localparam int AGG_MPIX = NUM_CH * CH_MPIX; // RULE9
   localparam int EXT_MHZ_10 = LANE_MBPS_10 / DDR_BITS; // RULE10
   localparam int EXT_MHZ_8 = LANE_MBPS_8 / DDR_BITS; // RULE10
   // link clocks per word slot: word bits over bits per link clock
   localparam logic [2:0] SLOT_10 = 3'(WORD_W / DDR_BITS);
   localparam logic [2:0] SLOT_8 = 3'(8 / DDR_BITS);
   // sync lane codes, clock lane pattern and crc constants
   localparam logic [9:0] CODE_FS = 10'h2c0;
   localparam logic [9:0] CODE_LS = 10'h280;
   localparam logic [9:0] CODE_LE = 10'h240;
   localparam logic [9:0] CODE_FE = 10'h300;
   localparam logic [9:0] CODE_CRC = 10'h0c0;
   localparam logic [9:0] CODE_IMG = 10'h035;
   localparam logic [9:0] CODE_TRAIN = 10'h3a6;
   localparam logic [9:0] CLK_PATTERN = 10'h2aa;
   localparam logic [9:0] CRC_POLY = 10'h233;
   localparam logic [9:0] CRC_SEED = 10'h3ff;

   typedef enum logic [2:0] {
      K_PIX = 3'h0,
      K_FS = 3'h1,
      K_LS = 3'h2,
      K_LE = 3'h3,
      K_FE = 3'h4
   } spop_kind_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_ODD = 3'h2,
      S_LE = 3'h4
   } spop_st_t;

   typedef struct packed {
      spop_kind_t kind;
      logic [NUM_ADC-1:0][WORD_W-1:0] smp;
   } spop_item_t;

   typedef struct packed {
      logic [WORD_W-1:0] sync;
      logic [NUM_CH-1:0][WORD_W-1:0] dat;
   } spop_slot_t;

   function automatic logic [9:0] spop_crc_step(input logic [9:0] c, input logic [9:0] d);
      logic [9:0] r;
      logic fb;
      r = c;
      for (int i = 9; i >= 0; i--)
      begin
         fb = r[9] ^ d[i];
         r = {r[8:0], 1'b0};
         if (fb)
            r = r ^ CRC_POLY;
      end
      return r;
   endfunction
endpackage

// [tb/spop_output_path_tb.sv]
// Purpose: self-checking bench of the sensor pixel output path
// Assumes: link clock 12 ns, free running, phase unrelated to sys clock
// Notes: frames are judged at the receiver model and the parallel port
`timescale 1ns/100ps
`default_nettype none
module spop_output_path_tb;
   import spop_pkg::*;
   logic sys_clk_i = 1'b0;
   logic lnk_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic mode8_i = 1'b0;
   logic use_ext_clk_i = 1'b0;
   spop_item_t item_i = '0;
   logic item_valid_i = 1'b0;
   logic item_ready_o;
   logic [7:0] dat_ddr_o;
   logic [1:0] sync_ddr_o;
   logic [1:0] clk_ddr_o;
   logic pll_en_o;
   logic [9:0] par_data_o;
   logic par_fv_o;
   logic par_lv_o;
   logic lv_bad = 1'b0;
   logic [9:0] par_q[$];
   int n_fail = 0;
   int compares = 0;

   always #2.5 sys_clk_i = ~sys_clk_i;
   initial
   begin
      #1.7;
      forever #6 lnk_clk_i = ~lnk_clk_i;
   end

   spop_output_path dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .lnk_clk_i(lnk_clk_i), .mode8_i(mode8_i), .use_ext_clk_i(use_ext_clk_i),
      .item_i(item_i), .item_valid_i(item_valid_i), .item_ready_o(item_ready_o),
      .dat_ddr_o(dat_ddr_o), .sync_ddr_o(sync_ddr_o), .clk_ddr_o(clk_ddr_o),
      .pll_en_o(pll_en_o), .par_data_o(par_data_o), .par_fv_o(par_fv_o),
      .par_lv_o(par_lv_o));
   spop_rx_model rx (.lnk_clk_i(lnk_clk_i), .mode8_i(mode8_i),
      .dat_ddr_i(dat_ddr_o), .sync_ddr_i(sync_ddr_o));

   // line words as a parallel receiver would latch them
   always @(posedge lnk_clk_i)
      if (par_lv_o === 1'b1)
      begin
         par_q.push_back(par_data_o);
         if (par_fv_o !== 1'b1)
            lv_bad <= 1'b1;
      end

   task automatic chk_word(input string w, input logic [9:0] e, input logic [9:0] g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic chk_bit(input string w, input logic e, input logic g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value %s expected %b seen %b", w, e, g);
      end
   endtask

   function automatic logic [9:0] tr8(input logic [9:0] x, input logic m);
      return m ? {2'b00, x[9:2]} : x;
   endfunction

   // msb first, poly and seed from the package constants
   function automatic logic [9:0] crc_upd(input logic [9:0] c, input logic [9:0] d);
      for (int i = 9; i >= 0; i--)
         c = (c[9] ^ d[i]) ? ({c[8:0], 1'b0} ^ CRC_POLY) : {c[8:0], 1'b0};
      return c;
   endfunction

   // valid is held until the edge that samples ready high
   task automatic send(input spop_item_t it);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      item_i <= it;
      item_valid_i <= 1'b1;
      do
      begin
         @(negedge sys_clk_i);
         n++;
      end
      while (item_ready_o !== 1'b1 && n < 400);
      @(posedge sys_clk_i);
      item_valid_i <= 1'b0;
      chk_bit("item taken", 1'b1, n < 400);
   endtask

   task automatic run_frame(input logic m8, input int npix);
      spop_slot_t e[$];
      spop_slot_t s;
      spop_item_t it;
      logic [9:0] crc[NUM_CH];
      logic [9:0] wd;
      int n;
      @(posedge sys_clk_i);
      mode8_i <= m8;
      repeat (100) @(posedge sys_clk_i);
      rx.q.delete();
      par_q.delete();
      it = '0;
      s = '0;
      it.kind = K_FS;
      send(it);
      s.sync = CODE_FS;
      e.push_back(s);
      it.kind = K_LS;
      send(it);
      s.sync = CODE_LS;
      e.push_back(s);
      for (int k = 0; k < NUM_CH; k++)
         crc[k] = CRC_SEED;
      for (int p = 0; p < npix; p++)
      begin
         it.kind = K_PIX;
         for (int i = 0; i < NUM_ADC; i++)
            it.smp[i] = (p == 0) ? ((i % 2) ? 10'h3ff : 10'h000) : 10'((p * 97 + i * 53) % 1024);
         send(it);
         for (int h = 0; h < 2; h++)
         begin
            s.sync = CODE_IMG;
            for (int k = 0; k < NUM_CH; k++)
            begin
               wd = it.smp[2*k+h];
               s.dat[k] = tr8(wd, m8);
               crc[k] = crc_upd(crc[k], m8 ? {wd[9:2], 2'b00} : wd);
            end
            e.push_back(s);
         end
      end
      s.sync = CODE_CRC;
      for (int k = 0; k < NUM_CH; k++)
         s.dat[k] = tr8(crc[k], m8);
      e.push_back(s);
      it.kind = K_LE;
      send(it);
      s.sync = CODE_LE;
      e.push_back(s);
      it.kind = K_FE;
      send(it);
      s.sync = CODE_FE;
      e.push_back(s);
      n = 0;
      while (rx.q.size() < e.size() && n < 4000)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      repeat (40) @(posedge sys_clk_i);
      chk_word("slot count", 10'(e.size()), 10'(rx.q.size()));
      for (int j = 0; j < e.size() && j < rx.q.size(); j++)
      begin
         chk_word("sync word", tr8(e[j].sync, m8), rx.q[j].sync);
         if (e[j].sync == CODE_IMG || e[j].sync == CODE_CRC)
            for (int k = 0; k < NUM_CH; k++)
               chk_word("lane word", e[j].dat[k], rx.q[j].dat[k]);
      end
      if (!m8)
      begin
         n = 0;
         chk_word("line words", 10'(8 * npix), 10'(par_q.size()));
         foreach (e[j])
            for (int k = 0; k < NUM_CH && e[j].sync == CODE_IMG; k++)
            begin
               if (n < par_q.size())
                  chk_word("line word", e[j].dat[k], par_q[n]);
               n++;
            end
      end
      chk_bit("lv outside frame", 1'b0, lv_bad);
      chk_bit("frame valid at rest", 1'b0, par_fv_o);
      chk_bit("line valid at rest", 1'b0, par_lv_o);
   endtask

   // three reset edges; the link side catches the pulse through its synchroniser
   task automatic t_reset();
      repeat (2) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk_bit("ready in reset", 1'b1, item_ready_o);
      chk_bit("pll in reset", 1'b1, pll_en_o);
      @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge lnk_clk_i);
      @(negedge lnk_clk_i);
      chk_word("lanes after reset", 10'h000, 10'(dat_ddr_o));
   endtask

   task automatic t_clock();
      repeat (40) @(posedge lnk_clk_i);
      repeat (5)
      begin
         @(negedge lnk_clk_i);
         chk_word("clock lane", 10'h002, 10'(clk_ddr_o));
      end
      @(posedge sys_clk_i);
      use_ext_clk_i <= 1'b1;
      @(negedge sys_clk_i);
      chk_bit("pll before sync", 1'b1, pll_en_o);
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk_bit("pll off", 1'b0, pll_en_o);
      @(posedge sys_clk_i);
      use_ext_clk_i <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk_bit("pll on", 1'b1, pll_en_o);
   endtask

   task automatic t_frame10();
      run_frame(1'b0, 2);
   endtask

   task automatic t_frame8();
      run_frame(1'b1, 1);
   endtask

   task automatic print_verdict();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      t_reset();
      t_clock();
      t_frame10();
      t_frame8();
      print_verdict();
   end

   initial
   begin
      #100000;
      n_fail++;
      $display("wrong value watchdog expected done seen hang");
      print_verdict();
   end
endmodule // spop_output_path_tb
`default_nettype wire

// [tb/spop_rx_model.sv]
// Purpose: receiving side model, turns the ddr lanes back into word slots
// Assumes: one link edge per bit pair, mode8_i steady while a frame runs
// Notes: word phase is found on the training word of the sync lane
`timescale 1ns/100ps
`default_nettype none
module spop_rx_model
   import spop_pkg::*;
(
   // link clock and mode
   input wire logic lnk_clk_i,
   input wire logic mode8_i,
   // lanes from the sensor
   input wire logic [7:0] dat_ddr_i,
   input wire logic [1:0] sync_ddr_i
);
   spop_slot_t sh_reg = '0;
   spop_slot_t q[$];
   int ph_reg = 0;

   // relocks on every training word, so a mode change needs no restart
   always @(posedge lnk_clk_i)
   begin : rx_shift
      spop_slot_t s;
      logic [9:0] tr;
      s.sync = {sh_reg.sync[7:0], sync_ddr_i};
      for (int k = 0; k < NUM_CH; k++)
         s.dat[k] = {sh_reg.dat[k][7:0], dat_ddr_i[2*k+1 -: 2]};
      sh_reg = s;
      tr = mode8_i ? {2'b00, CODE_TRAIN[9:2]} : CODE_TRAIN;
      if (mode8_i)
      begin
         s.sync[9:8] = 2'b00;
         for (int k = 0; k < NUM_CH; k++)
            s.dat[k][9:8] = 2'b00;
      end
      if (s.sync == tr)
         ph_reg = 0;
      else if (ph_reg == (mode8_i ? 3 : 4))
      begin
         ph_reg = 0;
         q.push_back(s);
      end
      else
         ph_reg++;
   end
endmodule // spop_rx_model
`default_nettype wire
